//--- cfgmp_pkg.sv
// constants and types for the configuration message port
package cfgmp_pkg;
  // ---------------------------------------------------------------
  // control tokens
  // ---------------------------------------------------------------
  localparam logic [7:0] TOK_WRITE     = 8'hc0;
  localparam logic [7:0] TOK_READ      = 8'hc1;
  localparam logic [7:0] TOK_OK        = 8'h03;
  localparam logic [7:0] TOK_FAIL      = 8'h04;
  localparam logic [7:0] TOK_END       = 8'h01;
  // ---------------------------------------------------------------
  // message layout, in bytes received after the opening token
  // ---------------------------------------------------------------
  localparam logic [3:0] DEST_END      = 4'h3;
  localparam logic [3:0] RD_LEN        = 4'h5;
  localparam logic [3:0] WR_LEN        = 4'h9;
  localparam logic [7:0] NO_REPLY_CHAN = 8'hff;
  localparam logic [2:0] RSP_LAST_SHORT = 3'h1;
  localparam logic [2:0] RSP_LAST_READ  = 3'h5;
  // ---------------------------------------------------------------
  // processor-status resource identifier
  // ---------------------------------------------------------------
  localparam logic [7:0] PS_RID_TAG    = 8'h0b;
  localparam int         PS_NUM_LSB    = 8;
  // ---------------------------------------------------------------
  // register spaces
  // ---------------------------------------------------------------
  localparam logic [1:0] SPACE_TILE    = 2'h0;
  localparam logic [1:0] SPACE_NODE    = 2'h1;
  localparam logic [1:0] SPACE_PS      = 2'h2;
  // ---------------------------------------------------------------
  // boot timing
  // ---------------------------------------------------------------
  localparam int         CLK_MHZ       = 50;
  localparam int         T_INIT_US     = 150;
  localparam int         INIT_CYC      = T_INIT_US * CLK_MHZ;
  localparam int         INIT_W        = 16;
  localparam int         BOOT_MODE_W   = 2;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_HDR    = 7'h02,
    ST_DRAIN  = 7'h04,
    ST_ACC    = 7'h08,
    ST_REPLY  = 7'h10,
    ST_PS     = 7'h20,
    ST_PSDONE = 7'h40
  } cfgmp_state_e;
endpackage

//--- cfgmp_boot.sv
// boot start sequencer after reset release
`timescale 1ns/10ps
`default_nettype none
module cfgmp_boot #(
  parameter int INIT_CYCLES = cfgmp_pkg::INIT_CYC
) (
  input  wire logic                               clk_i,
  input  wire logic                               reset_n_i,
  input  wire logic                               pll_lock_i,
  input  wire logic [cfgmp_pkg::BOOT_MODE_W-1:0]  boot_mode_i,
  output logic                                    boot_start_o,
  output logic                                    booted_o,
  output logic      [cfgmp_pkg::BOOT_MODE_W-1:0]  boot_mode_o
);
  import cfgmp_pkg::*;
  localparam logic [INIT_W-1:0] LAST_CNT = INIT_W'(INIT_CYCLES - 1);

  logic                   lock_s1_r;
  logic                   lock_s2_r;
  logic [BOOT_MODE_W-1:0] mode_s1_r;
  logic [BOOT_MODE_W-1:0] mode_s2_r;
  logic [INIT_W-1:0]      cnt_r;
  logic                   booted_r;
  logic                   start_r;
  logic [BOOT_MODE_W-1:0] mode_r;
  logic                   go;

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      mode_s1_r <= '0;
      mode_s2_r <= '0;
    end else begin
      lock_s1_r <= pll_lock_i;
      lock_s2_r <= lock_s1_r;
      mode_s1_r <= boot_mode_i;
      mode_s2_r <= mode_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // lock wait with deadline
  // ---------------------------------------------------------------
  assign go = !booted_r && (lock_s2_r || cnt_r == LAST_CNT);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r    <= '0;
      booted_r <= 1'b0;
      start_r  <= 1'b0;
      mode_r   <= '0;
    end else begin
      start_r <= go;
      if (go) begin
        booted_r <= 1'b1;
        mode_r   <= mode_s2_r;
      end else if (!booted_r) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign boot_start_o = start_r;
  assign booted_o     = booted_r;
  assign boot_mode_o  = mode_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_init_bound;
    !booted_r |-> cnt_r <= LAST_CNT;
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("boot deadline passed");

  property p_lock_first;
    $rose(booted_r) |-> ($past(lock_s2_r) || $past(cnt_r) == LAST_CNT) ##1 !start_r;
  endproperty
  a_lock_first: assert property (p_lock_first) else $error("boot without lock or deadline");

  c_boot_lock: cover property (lock_s2_r && go && cnt_r < LAST_CNT);
endmodule
`default_nettype wire

//--- cfgmp_port.sv
// configuration register message port: token parser, access and reply
//
// Summary of operation
// - A write message is token 192, a 3-byte reply id, 2-byte register number, 4-byte data, token 1.
// - A read message is token 193, a 3-byte reply id, 2-byte register number, token 1.
// - A write is answered with tokens 3 and 1 on success or tokens 4 and 1 on failure.
// - A read is answered with token 3, the 4 data bytes and token 1, or with tokens 4 and 1 on failure.
// - Each message carries the upper 24 bits of the reply channel-end, used as reply destination.
// - A write whose reply id has all ones in its low byte gets no reply.
// - All multi-byte fields travel most significant byte first.
// - Processor-status registers are accessed a full word at a time, directly, outside the messages.
// - Boot starts no later than 150 us after reset is released.
// - After reset the clock multiplier lock is awaited, at most until the 150 us deadline, before boot starts in the selected mode.
`timescale 1ns/10ps
`default_nettype none
module cfgmp_port #(
  parameter int INIT_CYCLES = cfgmp_pkg::INIT_CYC
) (
  input  wire logic                               clk_i,
  input  wire logic                               reset_n_i,
  input  wire logic                               pll_lock_i,
  input  wire logic [cfgmp_pkg::BOOT_MODE_W-1:0]  boot_mode_i,
  output logic                                    boot_start_o,
  output logic                                    booted_o,
  output logic      [cfgmp_pkg::BOOT_MODE_W-1:0]  boot_mode_o,
  input  wire logic                               rx_valid_i,
  input  wire logic                               rx_ctrl_i,
  input  wire logic [7:0]                         rx_data_i,
  input  wire logic                               rx_node_i,
  output logic                                    rx_ready_o,
  output logic                                    tx_valid_o,
  output logic                                    tx_ctrl_o,
  output logic      [7:0]                         tx_data_o,
  output logic      [23:0]                        tx_dest_o,
  input  wire logic                               tx_ready_i,
  output logic                                    reg_req_o,
  output logic                                    reg_we_o,
  output logic      [1:0]                         reg_space_o,
  output logic      [15:0]                        reg_num_o,
  output logic      [31:0]                        reg_wdata_o,
  input  wire logic                               reg_ack_i,
  input  wire logic                               reg_ok_i,
  input  wire logic [31:0]                        reg_rdata_i,
  input  wire logic                               ps_req_i,
  input  wire logic                               ps_we_i,
  input  wire logic [31:0]                        ps_rid_i,
  input  wire logic [31:0]                        ps_wdata_i,
  output logic                                    ps_ready_o,
  output logic                                    ps_done_o,
  output logic                                    ps_ok_o,
  output logic      [31:0]                        ps_rdata_o
);
  import cfgmp_pkg::*;

  cfgmp_state_e st_r;
  logic [3:0]   cnt_r;
  logic         wr_r;
  logic         ok_r;
  logic [1:0]   space_r;
  logic [23:0]  dest_r;
  logic [15:0]  num_r;
  logic [31:0]  wd_r;
  logic [31:0]  rd_r;
  logic [2:0]   step_r;
  logic [8:0]   tok_r;
  logic         rx_fire;
  logic         tx_fire;
  logic         ps_fire;
  logic         tx_last;
  logic [3:0]   need;
  logic         is_end;
  logic         no_reply;

  // ---------------------------------------------------------------
  // boot sequencer
  // ---------------------------------------------------------------
  cfgmp_boot #(
    .INIT_CYCLES (INIT_CYCLES)
  ) u_boot (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .pll_lock_i   (pll_lock_i),
    .boot_mode_i  (boot_mode_i),
    .boot_start_o (boot_start_o),
    .booted_o     (booted_o),
    .boot_mode_o  (boot_mode_o)
  );

  // ---------------------------------------------------------------
  // reply token sequence
  // ---------------------------------------------------------------
  function automatic logic [8:0] rsp_tok(input logic [2:0] s, input logic ok, input logic rd,
                                         input logic [31:0] w);
    logic [8:0] t;
    t = {1'b1, TOK_END};
    if (s == 3'h0) begin
      t = {1'b1, ok ? TOK_OK : TOK_FAIL};
    end else if (ok && rd) begin
      unique case (s)
        3'h1:    t = {1'b0, w[31:24]};
        3'h2:    t = {1'b0, w[23:16]};
        3'h3:    t = {1'b0, w[15:8]};
        3'h4:    t = {1'b0, w[7:0]};
        default: t = {1'b1, TOK_END};
      endcase
    end
    return t;
  endfunction

  assign ps_ready_o = st_r == ST_IDLE;
  assign ps_fire    = ps_req_i && ps_ready_o;
  assign rx_ready_o = (st_r == ST_IDLE && !ps_req_i) || st_r == ST_HDR || st_r == ST_DRAIN;
  assign rx_fire    = rx_valid_i && rx_ready_o;
  assign tx_valid_o = st_r == ST_REPLY;
  assign tx_fire    = tx_valid_o && tx_ready_i;
  assign tx_last    = step_r == ((ok_r && !wr_r) ? RSP_LAST_READ : RSP_LAST_SHORT);
  assign need       = wr_r ? WR_LEN : RD_LEN;
  assign is_end     = rx_ctrl_i && rx_data_i == TOK_END;
  assign no_reply   = wr_r && dest_r[7:0] == NO_REPLY_CHAN;

  // ---------------------------------------------------------------
  // message sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r   <= ST_IDLE;
      cnt_r  <= '0;
      wr_r   <= 1'b0;
      ok_r   <= 1'b0;
      rd_r   <= '0;
      step_r <= '0;
      tok_r  <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          cnt_r <= '0;
          ok_r  <= 1'b0;
          if (ps_fire) begin
            wr_r <= ps_we_i;
            st_r <= (ps_rid_i[7:0] == PS_RID_TAG) ? ST_PS : ST_PSDONE;
          end else if (rx_fire) begin
            step_r <= '0;
            tok_r  <= {1'b1, TOK_FAIL};
            if (rx_ctrl_i && (rx_data_i == TOK_WRITE || rx_data_i == TOK_READ)) begin
              wr_r <= rx_data_i == TOK_WRITE;
              st_r <= ST_HDR;
            end else begin
              wr_r <= 1'b0;
              st_r <= is_end ? ST_REPLY : ST_DRAIN;
            end
          end
        end
        ST_HDR: begin
          if (rx_fire) begin
            if (rx_ctrl_i) begin
              if (is_end && cnt_r == need) begin
                st_r <= ST_ACC;
              end else begin
                st_r <= is_end ? ST_REPLY : ST_DRAIN;
              end
            end else if (cnt_r == need) begin
              st_r <= ST_DRAIN;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        ST_DRAIN: begin
          if (rx_fire && is_end) begin
            st_r <= ST_REPLY;
          end
        end
        ST_ACC: begin
          if (reg_ack_i) begin
            ok_r   <= reg_ok_i;
            rd_r   <= reg_rdata_i;
            step_r <= '0;
            tok_r  <= rsp_tok(3'h0, reg_ok_i, !wr_r, reg_rdata_i);
            st_r   <= no_reply ? ST_IDLE : ST_REPLY;
          end
        end
        ST_REPLY: begin
          if (tx_fire) begin
            step_r <= step_r + 1'b1;
            tok_r  <= rsp_tok(step_r + 1'b1, ok_r, !wr_r, rd_r);
            if (tx_last) begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_PS: begin
          if (reg_ack_i) begin
            ok_r <= reg_ok_i;
            rd_r <= reg_rdata_i;
            st_r <= ST_PSDONE;
          end
        end
        ST_PSDONE: begin
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // field capture, most significant byte first
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dest_r  <= '0;
      num_r   <= '0;
      wd_r    <= '0;
      space_r <= SPACE_TILE;
    end else if (ps_fire) begin
      num_r   <= ps_rid_i[PS_NUM_LSB +: 16];
      wd_r    <= ps_wdata_i;
      space_r <= SPACE_PS;
    end else if (rx_fire && st_r == ST_IDLE) begin
      dest_r  <= '0;
      space_r <= rx_node_i ? SPACE_NODE : SPACE_TILE;
    end else if (rx_fire && st_r == ST_HDR && !rx_ctrl_i && cnt_r != need) begin
      if (cnt_r < DEST_END) begin
        dest_r <= {dest_r[15:0], rx_data_i};
      end else if (cnt_r < RD_LEN) begin
        num_r <= {num_r[7:0], rx_data_i};
      end else begin
        wd_r <= {wd_r[23:0], rx_data_i};
      end
    end
  end

  assign tx_ctrl_o   = tok_r[8];
  assign tx_data_o   = tok_r[7:0];
  assign tx_dest_o   = dest_r;
  assign reg_req_o   = st_r == ST_ACC || st_r == ST_PS;
  assign reg_we_o    = wr_r;
  assign reg_space_o = space_r;
  assign reg_num_o   = num_r;
  assign reg_wdata_o = wd_r;
  assign ps_done_o   = st_r == ST_PSDONE;
  assign ps_ok_o     = ok_r;
  assign ps_rdata_o  = rd_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_write_frame;
    (st_r == ST_HDR && rx_fire && is_end && wr_r && cnt_r == WR_LEN) |=> st_r == ST_ACC && reg_we_o;
  endproperty
  a_write_frame: assert property (p_write_frame) else $error("write frame not taken");

  property p_read_frame;
    (st_r == ST_HDR && rx_fire && is_end && !wr_r && cnt_r == RD_LEN) |=> st_r == ST_ACC && !reg_we_o;
  endproperty
  a_read_frame: assert property (p_read_frame) else $error("read frame not taken");

  property p_first_tok;
    (st_r == ST_ACC && reg_ack_i && !no_reply) |=>
      tx_valid_o && tx_ctrl_o && tx_data_o == ($past(reg_ok_i) ? TOK_OK : TOK_FAIL);
  endproperty
  a_first_tok: assert property (p_first_tok) else $error("wrong status token");

  property p_read_data;
    (tx_fire && step_r == 3'h0 && ok_r && !wr_r) |=> !tx_ctrl_o && tx_data_o == rd_r[31:24];
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not msb first");

  property p_last_tok;
    (tx_valid_o && tx_last) |-> tx_ctrl_o && tx_data_o == TOK_END;
  endproperty
  a_last_tok: assert property (p_last_tok) else $error("reply not closed by end token");

  property p_suppress;
    (st_r == ST_ACC && reg_ack_i && no_reply) |=> st_r == ST_IDLE && !tx_valid_o;
  endproperty
  a_suppress: assert property (p_suppress) else $error("suppressed write replied");

  property p_msb_first;
    (rx_fire && st_r == ST_HDR && !rx_ctrl_i && cnt_r == 4'h4) |=> num_r == {$past(num_r[7:0]), $past(rx_data_i)};
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("register number order wrong");

  property p_bad_open;
    (st_r == ST_IDLE && rx_fire && !ps_req_i && !(rx_ctrl_i && (rx_data_i == TOK_WRITE || rx_data_i == TOK_READ)))
      |=> (st_r == ST_DRAIN || st_r == ST_REPLY) && tok_r == {1'b1, TOK_FAIL};
  endproperty
  a_bad_open: assert property (p_bad_open) else $error("bad opener not failed");

  property p_ps_word;
    (st_r == ST_PS && reg_ack_i) |=> ps_done_o && ps_rdata_o == $past(reg_rdata_i) ##1 ps_ready_o;
  endproperty
  a_ps_word: assert property (p_ps_word) else $error("status word not returned");

  c_write_ok:  cover property (tx_fire && tx_last && wr_r && ok_r);
  c_read_ok:   cover property (tx_fire && tx_last && !wr_r && ok_r);
  c_no_reply:  cover property (st_r == ST_ACC && reg_ack_i && no_reply);
  c_ps_access: cover property (ps_done_o && ps_ok_o);
endmodule
`default_nettype wire

//--- cfgmp_requester.sv
// requesting channel-end model: sends token messages, collects replies
`timescale 1ns/10ps
`default_nettype none
module cfgmp_requester (
  input  wire logic       clk_i,
  input  wire logic       rdy_i,
  output logic            vld_o,
  output logic            ctrl_o,
  output logic [7:0]      data_o,
  output logic            node_o,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_ctrl_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [8:0] q[$];
  logic       slow;
  int         stuck;
  initial begin
    {vld_o, ctrl_o, data_o, node_o, slow} = '0;
    tx_ready_o = 1'b1;
    stuck = 0;
  end
  // ---------------------------------------------------------------
  // reply sink, stalls every other cycle when slow
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) q.push_back({tx_ctrl_i, tx_data_i});
    #1;
    tx_ready_o = slow ? ~tx_ready_o : 1'b1;
  end
  // ---------------------------------------------------------------
  // token driver
  // ---------------------------------------------------------------
  task automatic put(input logic c, input logic [7:0] d);
    int n;
    n = 0;
    vld_o = 1'b1;
    ctrl_o = c;
    data_o = d;
    while (!rdy_i && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 200) stuck++;
    @(posedge clk_i);
    #1;
  endtask
  // released lines show the inverse of the last value
  task automatic release_bus();
    vld_o = 1'b0;
    data_o = ~data_o;
    ctrl_o = ~ctrl_o;
    @(posedge clk_i);
    #1;
  endtask
  task automatic send_msg(input logic [7:0] op, input logic [23:0] id, input logic [15:0] num,
                          input logic [31:0] dat, input logic wr, input logic nd);
    node_o = nd;
    put(1'b1, op);
    for (int i = 2; i >= 0; i--) put(1'b0, id[8*i+:8]);
    for (int i = 1; i >= 0; i--) put(1'b0, num[8*i+:8]);
    if (wr) for (int i = 3; i >= 0; i--) put(1'b0, dat[8*i+:8]);
    put(1'b1, 8'h01);
    release_bus();
  endtask
endmodule
`default_nettype wire

//--- cfgmp_port_test.sv
// self-checking bench for the configuration message port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end
module cfgmp_port_test;
  import cfgmp_pkg::*;
  localparam int INIT_N = 20;
  logic clk_i, reset_n_i, pll_lock_i, rx_valid_i, rx_ctrl_i, rx_node_i, rx_ready_o;
  logic [1:0] boot_mode_i, boot_mode_o, reg_space_o, cap_space;
  logic boot_start_o, booted_o, tx_valid_o, tx_ctrl_o, tx_ready_i, reg_req_o, reg_we_o;
  logic reg_ack_i, reg_ok_i, ps_req_i, ps_we_i, ps_ready_o, ps_done_o, ps_ok_o, rsp_ok, cap_we;
  logic [7:0] rx_data_i, tx_data_o;
  logic [23:0] tx_dest_o;
  logic [15:0] reg_num_o, cap_num;
  logic [31:0] reg_wdata_o, reg_rdata_i, ps_rid_i, ps_wdata_i, ps_rdata_o, rsp_data, cap_wdata;
  int failures, check_count, acc_n, lat, wcnt;
  cfgmp_port #(.INIT_CYCLES(INIT_N)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .pll_lock_i(pll_lock_i),
    .boot_mode_i(boot_mode_i), .boot_start_o(boot_start_o), .booted_o(booted_o), .boot_mode_o(boot_mode_o),
    .rx_valid_i(rx_valid_i), .rx_ctrl_i(rx_ctrl_i), .rx_data_i(rx_data_i), .rx_node_i(rx_node_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_ctrl_o(tx_ctrl_o), .tx_data_o(tx_data_o),
    .tx_dest_o(tx_dest_o), .tx_ready_i(tx_ready_i), .reg_req_o(reg_req_o), .reg_we_o(reg_we_o),
    .reg_space_o(reg_space_o), .reg_num_o(reg_num_o), .reg_wdata_o(reg_wdata_o), .reg_ack_i(reg_ack_i),
    .reg_ok_i(reg_ok_i), .reg_rdata_i(reg_rdata_i), .ps_req_i(ps_req_i), .ps_we_i(ps_we_i),
    .ps_rid_i(ps_rid_i), .ps_wdata_i(ps_wdata_i), .ps_ready_o(ps_ready_o), .ps_done_o(ps_done_o),
    .ps_ok_o(ps_ok_o), .ps_rdata_o(ps_rdata_o));
  cfgmp_requester req_u (.clk_i(clk_i), .rdy_i(rx_ready_o), .vld_o(rx_valid_i), .ctrl_o(rx_ctrl_i),
    .data_o(rx_data_i), .node_o(rx_node_i), .tx_valid_i(tx_valid_o), .tx_ctrl_i(tx_ctrl_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // register responder: ack after lat cycles, captures the access
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    #1;
    if (reg_ack_i) begin
      reg_ack_i = 1'b0;
      reg_rdata_i = ~rsp_data;
    end else if (reg_req_o) begin
      if (wcnt < lat) wcnt++;
      else begin
        wcnt = 0;
        {reg_ack_i, reg_ok_i, reg_rdata_i} = {1'b1, rsp_ok, rsp_data};
        {cap_we, cap_space, cap_num, cap_wdata} = {reg_we_o, reg_space_o, reg_num_o, reg_wdata_o};
        acc_n++;
      end
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wrap_up();
    failures = failures + req_u.stuck;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up();
    failures++;
    wrap_up();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_reply(input int n);
    int k;
    k = 0;
    while (req_u.q.size() < n && k < 300) begin
      tick(1);
      k++;
    end
    if (k >= 300) give_up();
    tick(6);
    `CHK(req_u.q.size(), n)
  endtask
  task automatic chk_short(input logic [7:0] first);
    wait_reply(2);
    `CHK(req_u.q[0], {1'b1, first});
    `CHK(req_u.q[1], 9'h101);
    req_u.q.delete();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_boot();
    int n;
    n = 0;
    while (!boot_start_o && n < INIT_N + 10) begin
      tick(1);
      n++;
    end
    if (n >= INIT_N + 10) give_up();
    `CHK((n >= INIT_N - 1) && (n <= INIT_N + 1), 1'b1);
    tick(1);
    `CHK(booted_o, 1'b1);
    reset_n_i = 1'b0;
    pll_lock_i = 1'b1;
    boot_mode_i = 2'h2;
    tick(2);
    `CHK(booted_o, 1'b0);
    reset_n_i = 1'b1;
    n = 0;
    while (!boot_start_o && n < INIT_N) begin
      tick(1);
      n++;
    end
    if (n >= INIT_N) give_up();
    `CHK(n <= 6, 1'b1);
    tick(1);
    `CHK(boot_mode_o, 2'h2);
  endtask
  task automatic t_write();
    for (int ok = 1; ok >= 0; ok--) begin
      rsp_ok = ok[0];
      req_u.send_msg(TOK_WRITE, 24'h123405, 16'h0a0b, 32'hdeadbeef, 1'b1, 1'b0);
      `CHK(tx_dest_o, 24'h123405);
      chk_short(ok ? TOK_OK : TOK_FAIL);
      `CHK({cap_we, cap_space, cap_num, cap_wdata}, {1'b1, SPACE_TILE, 16'h0a0b, 32'hdeadbeef});
    end
  endtask
  task automatic t_read();
    req_u.slow = 1'b1;
    rsp_data = 32'h89abcdef;
    lat = 3;
    for (int ok = 1; ok >= 0; ok--) begin
      rsp_ok = ok[0];
      req_u.send_msg(TOK_READ, 24'h002107, 16'h0102, 32'h0, 1'b0, 1'b1);
      if (ok) begin
        wait_reply(6);
        `CHK({req_u.q[0], req_u.q[5]}, {9'h103, 9'h101});
        for (int i = 0; i < 4; i++) `CHK(req_u.q[i+1], {1'b0, rsp_data[8*(3-i)+:8]})
        req_u.q.delete();
      end else chk_short(TOK_FAIL);
      `CHK({cap_we, cap_space, cap_num}, {1'b0, SPACE_NODE, 16'h0102});
    end
    req_u.slow = 1'b0;
    lat = 0;
  endtask
  task automatic t_noreply();
    for (int ok = 1; ok >= 0; ok--) begin
      rsp_ok = ok[0];
      req_u.send_msg(TOK_WRITE, 24'h5566ff, 16'h0007, 32'h00000001 << ok, 1'b1, 1'b0);
      tick(20);
      `CHK(req_u.q.size(), 0);
      `CHK(cap_wdata, 32'h00000001 << ok);
    end
  endtask
  task automatic t_bad();
    int a;
    a = acc_n;
    req_u.put(1'b1, 8'hc5);
    req_u.put(1'b0, 8'h11);
    req_u.put(1'b1, 8'h01);
    req_u.release_bus();
    chk_short(TOK_FAIL);
    req_u.put(1'b1, TOK_READ);
    req_u.put(1'b0, 8'haa);
    req_u.put(1'b1, 8'h01);
    req_u.release_bus();
    chk_short(TOK_FAIL);
    `CHK(acc_n, a);
  endtask
  task automatic ps_op(input logic we, input logic [31:0] rid, input logic ok_exp, input int acc_exp);
    int k;
    k = 0;
    {ps_req_i, ps_we_i, ps_rid_i, ps_wdata_i} = {1'b1, we, rid, 32'hcafe0123};
    tick(1);
    {ps_req_i, ps_rid_i} = {1'b0, ~rid};
    while (!ps_done_o && k < 100) begin
      tick(1);
      k++;
    end
    if (k >= 100) give_up();
    `CHK(ps_ok_o, ok_exp);
    `CHK(acc_n, acc_exp);
    if (ok_exp) begin
      `CHK({cap_we, cap_space, cap_num}, {we, SPACE_PS, rid[23:8]});
      if (we) `CHK(cap_wdata, 32'hcafe0123)
      else `CHK(ps_rdata_o, rsp_data)
    end
    tick(2);
  endtask
  task automatic t_ps();
    rsp_ok = 1'b1;
    rsp_data = 32'h00040000;
    ps_op(1'b0, {8'h00, 16'h0003, PS_RID_TAG}, 1'b1, acc_n + 1);
    ps_op(1'b1, {8'h00, 16'h0002, PS_RID_TAG}, 1'b1, acc_n + 1);
    ps_op(1'b0, {8'h00, 16'h0003, 8'h0a}, 1'b0, acc_n);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {failures, check_count, acc_n, lat, wcnt} = '0;
    {reset_n_i, pll_lock_i, boot_mode_i, reg_ack_i, reg_ok_i, rsp_ok} = '0;
    {ps_req_i, ps_we_i, ps_rid_i, ps_wdata_i, reg_rdata_i} = '0;
    rsp_data = 32'h0;
    tick(8);
    `CHK({tx_valid_o, reg_req_o, ps_ready_o, boot_start_o}, 4'h2);
    reset_n_i = 1'b1;
    t_boot();
    t_write();
    t_read();
    t_noreply();
    t_bad();
    t_ps();
    wrap_up();
  end
endmodule
`default_nettype wire
